// ===== core/dcos_cfg.svh
// Notes on behaviour
// [R01] Software sets either override bit by writing one to it.
// [R02] Writing zero never clears a set override bit.
// [R03] Drive 1 override clears when step_pulse_n AND drive_select1_n is true.
// [R04] Drive 0 override clears when step_pulse_n AND drive_select0_n is true.
// [R05] Status equals (ds0_n AND ovr0) OR (ds1_n AND ovr1) OR disk_change_in_n.
// [R06] A set override forces disk change active for the selected drive.
// [R07] Override bit 0 is drive 0, bit 1 is drive 1, one means active.
// [R08] Override bits 7:2 are reserved and read zero.
// [R09] Override register is read-write at 1E, reset value 0x03.
// [R10] Rate shadow is read-only, reset 0x02 on every reset.
// [R11] Rate shadow bits 1:0 hold the data rate select.
// [R12] Rate shadow bits 4:2 hold precompensation select, bit 5 reserved.
// [R13] Rate shadow bit 6 is power-down, bit 7 is soft reset.
// [R14] Serial queue shadow is read-only, reset 0x00.
// [R15] Serial shadow bit 1 is receive clear, bit 2 transmit clear.
// [R16] Serial shadow bit 3 is DMA mode select.
// [R17] Serial shadow bit 0 queue enable, bits 5:4 reserved, 7:6 trigger level.
// [R18] Each shadow captures the last write to its write-only control register.
// [R19] Writes to the shadow addresses change nothing.
`ifndef DCOS_CFG_SVH
`define DCOS_CFG_SVH
`define DCOS_OFS_OVERRIDE     8'h1e
`define DCOS_OFS_RATE_SHADOW  8'h1f
`define DCOS_OFS_QUEUE_SHADOW 8'h20
`define DCOS_RST_OVERRIDE     8'h03
`define DCOS_RST_RATE         8'h02
`define DCOS_RST_QUEUE        8'h00
`define DCOS_OVR_MASK         8'h03
`define DCOS_RATE_MASK        8'hdf
`define DCOS_QUEUE_MASK       8'hcf
`endif

// ===== core/dcos_pkg.sv
package dcos_pkg;
   // Data rate shadow layout
   typedef struct packed {
      logic       soft_reset;
      logic       power_down;
      logic       rsvd;
      logic [2:0] write_select_a;
      logic [1:0] rate_sel;
   } dcos_rate_t;
   // Serial queue control shadow layout
   typedef struct packed {
      logic [1:0] rx_trigger_level;
      logic [1:0] rsvd;
      logic       dma_mode;
      logic       tx_queue_clear;
      logic       rx_queue_clear;
      logic       queue_enable;
   } dcos_queue_t;
endpackage : dcos_pkg

// ===== core/dcos_top.sv
// Decided for this implementation: the strobed register port.
`timescale 1ns/10ps
`default_nettype none
`include "dcos_cfg.svh"
module dcos_top #(
   parameter int ADDR_W = 8
) (
   input  wire logic              clk,
   input  wire logic              rst_b,
   input  wire logic              hard_reset,
   input  wire logic              standby_supply_power_on_reset,
   input  wire logic [ADDR_W-1:0] reg_addr,
   input  wire logic [7:0]        reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic [7:0]             reg_rdata,
   input  wire logic              rate_ctrl_wr,
   input  wire logic [7:0]        rate_ctrl_data,
   input  wire logic              queue_ctrl_wr,
   input  wire logic [7:0]        queue_ctrl_data,
   input  wire logic              step_pulse_n,
   input  wire logic              drive_select0_n,
   input  wire logic              drive_select1_n,
   input  wire logic              disk_change_in_n,
   output logic                   disk_changed_status
);

   // ------------------------------------------------
   // Elaboration checks
   // ------------------------------------------------
   // Map reaches offset 0x20, so six address bits at least
   if (ADDR_W < 6) begin : g_addr_narrow
      $error("ADDR_W too small for the register map");
   end

   // Host decode never offers more than sixteen bits
   if (ADDR_W > 16) begin : g_addr_wide
      $error("ADDR_W wider than the host decode");
   end

   // Highest offset must fit the address width
   if ((8'(`DCOS_OFS_QUEUE_SHADOW) >> ADDR_W) != 8'h00) begin : g_ofs_fit
      $error("Register offsets do not fit ADDR_W");
   end

   // Override and queue offsets each distinct from rate, or reads would hide each other
   if (`DCOS_OFS_OVERRIDE == `DCOS_OFS_RATE_SHADOW || `DCOS_OFS_RATE_SHADOW == `DCOS_OFS_QUEUE_SHADOW) begin : g_ofs_clash
      $error("Register offsets overlap");
   end

   // Rate copy must keep its reserved bit 5 low
   if ((`DCOS_RATE_MASK & 8'h20) != 8'h00) begin : g_rate_mask
      $error("Rate mask lets the reserved bit through");
   end

   // Rate reset value must not set the reserved bit
   if ((`DCOS_RST_RATE & ~`DCOS_RATE_MASK) != 8'h00) begin : g_rate_reset
      $error("Rate reset value sets a reserved bit");
   end

   // Queue copy must keep its reserved bits 5:4 low
   if ((`DCOS_QUEUE_MASK & 8'h30) != 8'h00) begin : g_queue_mask
      $error("Queue mask lets the reserved bits through");
   end

   // Override reset value must fit the two live bits
   if ((`DCOS_RST_OVERRIDE & ~`DCOS_OVR_MASK) != 8'h00) begin : g_ovr_reset
      $error("Override reset value sets a reserved bit");
   end

   // ------------------------------------------------
   // Map constants
   // ------------------------------------------------
   // Offsets and reset values at their working widths
   localparam logic [7:0] OFS_OVERRIDE = `DCOS_OFS_OVERRIDE;     // Read-write override
   localparam logic [7:0] OFS_RATE     = `DCOS_OFS_RATE_SHADOW;  // Read-only rate copy
   localparam logic [7:0] OFS_QUEUE    = `DCOS_OFS_QUEUE_SHADOW; // Read-only queue copy
   localparam logic [1:0] RST_OVR      = 2'(`DCOS_RST_OVERRIDE); // Both overrides active
   localparam logic [7:0] RST_RATE     = `DCOS_RST_RATE;         // Rate copy after reset
   localparam logic [7:0] RST_QUEUE    = `DCOS_RST_QUEUE;        // Queue copy after reset

   // ------------------------------------------------
   // Helper functions
   // ------------------------------------------------
   // Address match against one map offset
   function automatic logic addr_hit(
      input logic [ADDR_W-1:0] addr,
      input logic [7:0]        ofs
   );
      return addr == ADDR_W'(ofs);
   endfunction : addr_hit

   // Pin clear term for one drive: step and select both high
   function automatic logic pin_clear(
      input logic step_n,
      input logic select_n
   );
      return step_n & select_n;
   endfunction : pin_clear

   // Forced change for one drive: select high with override set
   function automatic logic force_term(
      input logic select_n,
      input logic ovr
   );
      return select_n & ovr;
   endfunction : force_term

   // Rate value with its reserved bit forced low
   function automatic dcos_pkg::dcos_rate_t rate_clean(
      input logic [7:0] raw
   );
      return dcos_pkg::dcos_rate_t'(raw & `DCOS_RATE_MASK);
   endfunction : rate_clean

   // Queue value with its reserved bits forced low
   function automatic dcos_pkg::dcos_queue_t queue_clean(
      input logic [7:0] raw
   );
      return dcos_pkg::dcos_queue_t'(raw & `DCOS_QUEUE_MASK);
   endfunction : queue_clean

   // Read value for one address; unmapped offsets read zero
   function automatic logic [7:0] read_pick(
      input logic [ADDR_W-1:0] addr,
      input logic [1:0]        ovr,
      input logic [7:0]        rate,
      input logic [7:0]        queue
   );
      logic [7:0] value;
      value = 8'h00;
      if (addr_hit(addr, OFS_OVERRIDE)) begin
         value = {6'h00, ovr}; // [R07] [R08]
      end else if (addr_hit(addr, OFS_RATE)) begin
         value = rate; // [R11] [R12] [R13]
      end else if (addr_hit(addr, OFS_QUEUE)) begin
         value = queue; // [R15] [R16] [R17]
      end
      return value;
   endfunction : read_pick

   // ------------------------------------------------
   // State and decode signals
   // ------------------------------------------------
   logic                  ovr0_reg;     // Drive 0 override
   logic                  ovr0_next;    // Next drive 0 override
   logic                  ovr1_reg;     // Drive 1 override
   logic                  ovr1_next;    // Next drive 1 override
   logic [1:0]            ovr_reg;      // Both overrides, drive 1 above drive 0
   logic [1:0]            ovr_clear;    // Pin clear request per drive
   logic [1:0]            ovr_set;      // Software set request per drive
   logic [1:0]            force_chg;    // Forced change per drive
   dcos_pkg::dcos_rate_t  rate_reg;     // Rate control copy
   dcos_pkg::dcos_rate_t  rate_next;    // Next rate copy
   dcos_pkg::dcos_queue_t queue_reg;    // Queue control copy
   dcos_pkg::dcos_queue_t queue_next;   // Next queue copy
   logic [7:0]            rdata_reg;    // Read data register
   logic [7:0]            rdata_next;   // Next read data
   logic                  wr_ovr;       // Bus write to the override
   logic                  shadow_reset; // Hard or standby reset of the copies

   // ------------------------------------------------
   // Bus and pin decode
   // ------------------------------------------------
   // Only the override offset accepts writes
   assign wr_ovr       = reg_wr && addr_hit(reg_addr, OFS_OVERRIDE); // [R09] [R19]
   // Copies return to defaults on either synchronous reset
   assign shadow_reset = hard_reset || standby_supply_power_on_reset; // [R10] [R14]
   // Per-drive clear from step and select pins
   assign ovr_clear[0] = pin_clear(step_pulse_n, drive_select0_n); // [R04]
   assign ovr_clear[1] = pin_clear(step_pulse_n, drive_select1_n); // [R03]
   // Software can only raise bits
   assign ovr_set      = wr_ovr ? reg_wdata[1:0] : 2'h0; // [R01] [R07]

   // ------------------------------------------------
   // Drive 0 override
   // ------------------------------------------------
   // Pin clear, then software set wins, hard reset last
   always_comb begin
      ovr0_next = ovr0_reg;
      if (ovr_clear[0]) begin
         ovr0_next = 1'b0; // [R04]
      end
      if (ovr_set[0]) begin
         ovr0_next = 1'b1; // [R01] [R02]
      end
      if (hard_reset) begin
         ovr0_next = RST_OVR[0]; // [R09]
      end
   end

   // Drive 0 override register
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ovr0_reg <= RST_OVR[0]; // [R09]
      end else begin
         ovr0_reg <= ovr0_next;
      end
   end

   // ------------------------------------------------
   // Drive 1 override
   // ------------------------------------------------
   // Pin clear, then software set wins, hard reset last
   always_comb begin
      ovr1_next = ovr1_reg;
      if (ovr_clear[1]) begin
         ovr1_next = 1'b0; // [R03]
      end
      if (ovr_set[1]) begin
         ovr1_next = 1'b1; // [R01] [R02]
      end
      if (hard_reset) begin
         ovr1_next = RST_OVR[1]; // [R09]
      end
   end

   // Drive 1 override register
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ovr1_reg <= RST_OVR[1]; // [R09]
      end else begin
         ovr1_reg <= ovr1_next;
      end
   end

   // ------------------------------------------------
   // Disk-changed status
   // ------------------------------------------------
   // Override bits in register order
   assign ovr_reg      = {ovr1_reg, ovr0_reg}; // [R07]
   // Forced change per drive while its select is high
   assign force_chg[0] = force_term(drive_select0_n, ovr0_reg); // [R06]
   assign force_chg[1] = force_term(drive_select1_n, ovr1_reg); // [R06]
   // Either forced term or the real change input
   assign disk_changed_status = force_chg[0] | force_chg[1] | disk_change_in_n; // [R05]

   // ------------------------------------------------
   // Rate copy
   // ------------------------------------------------
   // Capture control writes; bus writes never reach it
   always_comb begin
      rate_next = rate_reg;
      if (shadow_reset) begin
         rate_next = rate_clean(RST_RATE); // [R10]
      end else if (rate_ctrl_wr) begin
         rate_next = rate_clean(rate_ctrl_data); // [R18] [R11] [R12] [R13]
      end
   end

   // Rate copy register
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rate_reg <= dcos_pkg::dcos_rate_t'(RST_RATE); // [R10]
      end else begin
         rate_reg <= rate_next;
      end
   end

   // ------------------------------------------------
   // Queue copy
   // ------------------------------------------------
   // Capture control writes; bus writes never reach it
   always_comb begin
      queue_next = queue_reg;
      if (shadow_reset) begin
         queue_next = queue_clean(RST_QUEUE); // [R14]
      end else if (queue_ctrl_wr) begin
         queue_next = queue_clean(queue_ctrl_data); // [R18] [R15] [R16] [R17]
      end
   end

   // Queue copy register
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         queue_reg <= dcos_pkg::dcos_queue_t'(RST_QUEUE); // [R14]
      end else begin
         queue_reg <= queue_next; // [R19]
      end
   end

   // ------------------------------------------------
   // Read port
   // ------------------------------------------------
   // Data for the cycle after the strobe, zero otherwise
   always_comb begin
      rdata_next = 8'h00;
      if (reg_rd) begin
         rdata_next = read_pick(reg_addr, ovr_reg, rate_reg, queue_reg);
      end
   end

   // Read data register
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rdata_reg <= 8'h00;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   // Read data straight from the register
   assign reg_rdata = rdata_reg;
endmodule : dcos_top
`default_nettype wire

// ===== dv/dcos_chk_asserts.sv
`timescale 1ns/10ps
`default_nettype none
// Port checks on override and read-back
module dcos_chk (
   input wire logic       clk,
   input wire logic       rst_b,
   input wire logic       hard_reset,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic       step_pulse_n,
   input wire logic       drive_select0_n,
   input wire logic       drive_select1_n,
   input wire logic       disk_change_in_n,
   input wire logic       disk_changed_status
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   // Only one override term visible
   wire o0 = drive_select0_n & !drive_select1_n & !disk_change_in_n;
   wire o1 = drive_select1_n & !drive_select0_n & !disk_change_in_n;
   wire s = disk_changed_status;
   wire w = reg_wr & reg_addr == 8'h1e;
   a_din_status: assert property (disk_change_in_n |-> s) else $error("status");
   a_no_force: assert property (!disk_change_in_n & !drive_select0_n & !drive_select1_n |-> !s) else $error("force");
   a_sw_set: assert property (o0 & w & reg_wdata[0] ##1 o0 |-> s) else $error("set");
   a_sw_keep: assert property (o0 & s & !step_pulse_n ##1 o0 |-> s) else $error("keep");
   a_step_clr0: assert property (o0 & step_pulse_n & !reg_wr & !hard_reset ##1 o0 |-> !s) else $error("clr0");
   a_step_clr1: assert property (o1 & step_pulse_n & !reg_wr & !hard_reset ##1 o1 |-> !s) else $error("clr1");
   a_hard_set: assert property (hard_reset ##1 o1 |-> s) else $error("hard");
   a_rsvd_zero: assert property (reg_rd & reg_addr == 8'h1e |=> reg_rdata[7:2] == 6'h00) else $error("rsvd");
endmodule : dcos_chk
bind dcos_top dcos_chk u_chk (.*);
`default_nettype wire

// ===== dv/dcos_drive.sv
`timescale 1ns/10ps
`default_nettype none
// Drive side: reports its media change line
module dcos_drive (
   input wire logic chg,
   output logic     disk_change_in_n
);
   assign disk_change_in_n = chg;
endmodule : dcos_drive
`default_nettype wire

// ===== dv/disk_change_override_shadows_bench.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin errors++; $display("[ERR] %0t got %h", $time, a); end end
module disk_change_override_shadows_bench;
   logic clk = 0, rst_b = 0, hard_reset = 0, standby_supply_power_on_reset = 0, chg = 0;
   logic [7:0] reg_addr = 0, reg_wdata = 0, rate_ctrl_data = 0, queue_ctrl_data = 0, reg_rdata;
   logic reg_wr = 0, reg_rd = 0, rate_ctrl_wr = 0, queue_ctrl_wr = 0, disk_change_in_n;
   logic step_pulse_n = 0, drive_select0_n = 0, drive_select1_n = 0, disk_changed_status;
   logic [7:0] o = 8'h03, rt = 8'h02, q = 8'h00, pend = 8'h00;
   logic [31:0] r = 32'hbd91;
   int errors = 0, n_tests = 0, cyc = 0;
   always #5 clk = !clk;
   dcos_top u_dut (.*);
   dcos_drive u_drv (.*);
   // Random source
   function automatic logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs
   // Verdict
   task automatic end_sim;
      $display("errors %0d tests %0d", errors, n_tests);
      if (errors == 0 && n_tests > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : end_sim
   // Cycle ceiling
   always @(posedge clk) begin
      cyc++;
      if (cyc == 2000) begin errors++; end_sim(); end
   end
   // Random pins and register traffic against the model
   initial begin
      repeat (16) @(posedge clk);
      rst_b <= 1;
      repeat (500) begin
         @(posedge clk);
         r = xs(r);
         {step_pulse_n, drive_select0_n, drive_select1_n, chg, reg_wr} <= r[4:0];
         reg_rd <= !r[0] & r[7];
         reg_addr <= 8'h1e + 8'(r[6:5]);
         {reg_wdata, queue_ctrl_data, rate_ctrl_data} <= {r[15:8], r[23:16], r[31:24]};
         {rate_ctrl_wr, queue_ctrl_wr} <= r[17:16];
         hard_reset <= r[21:18] == 0;
         standby_supply_power_on_reset <= r[25:22] == 0;
         @(negedge clk);
         `CHK(reg_rdata, pend)
         `CHK(disk_changed_status, (drive_select0_n & o[0]) | (drive_select1_n & o[1]) | chg)
         pend = !reg_rd ? 8'h00 : reg_addr == 8'h1e ? o : reg_addr == 8'h1f ? rt : reg_addr == 8'h20 ? q : 8'h00;
         o = hard_reset ? 8'h03 : (o & ~{6'h00, step_pulse_n & drive_select1_n, step_pulse_n & drive_select0_n})
             | (reg_wr && reg_addr == 8'h1e ? reg_wdata & 8'h03 : 8'h00);
         if (hard_reset || standby_supply_power_on_reset) {rt, q} = 16'h0200;
         else begin
            if (rate_ctrl_wr) rt = rate_ctrl_data & 8'hdf;
            if (queue_ctrl_wr) q = queue_ctrl_data & 8'hcf;
         end
      end
      end_sim();
   end
endmodule : disk_change_override_shadows_bench
`default_nettype wire
